// ===== verification/rrr_ring_slave.sv
// Ring slave agents answering the manager's requests
`timescale 1ns/10ps
module rrr_ring_slave
	import rrr_pkg::*;
#(
	parameter int         LAT      = 3,
	parameter logic [5:0] ERR_TAG  = 6'h1A,
	// Nobody on the ring claims this tag, so such a request comes back round
	parameter logic [5:0] GONE_TAG = 6'h19
)
(
	input  wire logic     mclk,
	input  wire logic     nrst,
	input  wire logic     outValid,
	input  wire rrr_pkt_s outPkt,
	output logic          inValid,
	output rrr_pkt_s      inPkt
);
	int       cnt = 0;
	logic     take;
	rrr_pkt_s held;
	initial
	begin
		inValid = 1'b0;
		inPkt   = '0;
	end
	// Idle lines toggle so a stale packet never reads as fresh data
	always @(posedge mclk)
	begin
		take = nrst && outValid && outPkt.isReq && outPkt.sourceTag == 6'h20;
		if (take && outPkt.destinationTag == GONE_TAG)
			held = outPkt;
		else if (take)
			held = '{1'b0, 1'b0, 6'h20, outPkt.destinationTag == ERR_TAG ? 6'h3E
				: outPkt.destinationTag, outPkt.addr,
				{11'h000, outPkt.destinationTag, outPkt.addr}};
		#1;
		inValid = 1'b0;
		inPkt   = ~inPkt;
		if (!nrst)
			cnt = 0;
		else if (cnt == 1)
		begin
			inValid = 1'b1;
			inPkt   = held;
		end
		if (cnt > 0)
			cnt--;
		if (take)
			cnt = LAT;
	end
endmodule

// ===== verification/rrr_router_checker.sv
// Port assertions for the register ring router
`timescale 1ns/10ps
module rrr_router_checker
	import rrr_pkg::*;
(
	input wire logic     mclk,
	input wire logic     nrst,
	input wire logic     reqCredit,
	input wire logic     rspValid,
	input wire rrr_rsp_s rspPkt,
	input wire logic     ringInValid,
	input wire rrr_pkt_s ringInPkt,
	input wire logic     ringOutValid,
	input wire rrr_pkt_s ringOutPkt
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire  inReq   = ringInValid && ringInPkt.isReq;
	wire  ownOut  = ringOutValid && ringOutPkt.isReq && ringOutPkt.sourceTag == 6'h20;
	wire  ownBack = inReq && ringInPkt.sourceTag == 6'h20 && ringInPkt.destinationTag != 6'h20;
	wire  slvReq  = inReq && ringInPkt.destinationTag == 6'h20 && ringInPkt.sourceTag != 6'h20;
	wire  errAns  = ringInValid && !ringInPkt.isReq && ringInPkt.sourceTag == 6'h3E
		&& ringInPkt.destinationTag == 6'h20;
	wire  passIn  = ringInValid && ringInPkt.destinationTag != 6'h20 && !ownBack;
	logic busy_r;
	// Cleared by any response since requests are served strictly one at a time
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			busy_r <= 1'b0;
		else if (ownOut)
			busy_r <= 1'b1;
		else if (rspValid)
			busy_r <= 1'b0;
	chk_pass_through: assert property (passIn |=> ringOutValid && ringOutPkt == $past(ringInPkt))
		else $error("passing packet altered");
	chk_own_eaten: assert property (ownBack |=> !(ringOutValid && ringOutPkt == $past(ringInPkt)))
		else $error("unclaimed request sent round again");
	chk_err_reply: assert property ((errAns || ownBack) |-> ##[1:8] rspValid && rspPkt.err)
		else $error("no error response");
	chk_dest_legal: assert property (ownOut |-> ringOutPkt.destinationTag inside
		{[6'h00:6'h05], 6'h10, 6'h11, [6'h18:6'h1A], [6'h20:6'h25]})
		else $error("reserved tag on ring");
	chk_slave_reply: assert property (slvReq |-> ##[1:8] ringOutValid && !ringOutPkt.isReq
		&& ringOutPkt.sourceTag == 6'h20)
		else $error("manager slave did not answer");
	chk_rsp_pulse: assert property (rspValid |=> !rspValid)
		else $error("response longer than a cycle");
	chk_credit_back: assert property (rspValid |-> reqCredit)
		else $error("no credit with response");
	chk_one_flight: assert property (ownOut |-> !busy_r)
		else $error("second ring request in flight");
	cover property (ownOut);
	cover property (slvReq);
	cover property (errAns);
	cover property (ownBack);
endmodule
bind rrr_router rrr_router_checker u_chk (.mclk(mclk), .nrst(nrst), .reqCredit(reqCredit),
	.rspValid(rspValid), .rspPkt(rspPkt), .ringInValid(ringInValid), .ringInPkt(ringInPkt),
	.ringOutValid(ringOutValid), .ringOutPkt(ringOutPkt));

// ===== verification/tb_top.sv
// Self-checking bench for the register ring router
`timescale 1ns/10ps
module tb_top;
	import rrr_pkg::*;
	localparam logic [47:0] BASE = 48'h0000_2468_0000;
	logic     mclk      = 1'b0;
	logic     nrst      = 1'b0;
	logic     reqValid  = 1'b0;
	logic     rspCredit = 1'b0;
	logic     injV      = 1'b0;
	logic     reqCredit, rspValid, ringOutValid, slvV;
	rrr_req_s reqPkt = '0;
	rrr_pkt_s injPkt = '0;
	rrr_rsp_s rspPkt, got;
	rrr_pkt_s ringOutPkt, slvPkt, lastOut;
	int       failures = 0;
	int       checked  = 0;
	int       issues   = 0;
	int       sent     = 0;
	int       credits  = 0;
	int       rsps     = 0;
	wire      ringInV = injV | slvV;
	rrr_pkt_s ringIn;
	assign ringIn = injV ? injPkt : slvPkt;
	always #50 mclk = ~mclk;
	always @(posedge mclk)
		if (ringOutValid === 1'b1 && ringOutPkt.isReq && ringOutPkt.sourceTag == 6'h20)
		begin
			lastOut = ringOutPkt;
			issues++;
		end
	// Two request credits leave reset, then one comes back with every response
	always @(posedge mclk)
	begin
		if (nrst && reqCredit === 1'b1)
			credits++;
		if (nrst && rspValid === 1'b1)
			rsps++;
	end
	rrr_router dut (.mclk(mclk), .nrst(nrst), .configWindowBase(BASE[47:15]),
		.reqValid(reqValid), .reqPkt(reqPkt), .reqCredit(reqCredit), .rspValid(rspValid),
		.rspPkt(rspPkt), .rspCredit(rspCredit), .ringInValid(ringInV), .ringInPkt(ringIn),
		.ringOutValid(ringOutValid), .ringOutPkt(ringOutPkt));
	rrr_ring_slave #(.LAT(3), .ERR_TAG(6'h1A), .GONE_TAG(6'h19)) slv (.mclk(mclk),
		.nrst(nrst), .outValid(ringOutValid), .outPkt(ringOutPkt), .inValid(slvV),
		.inPkt(slvPkt));
	task automatic test_done();
		if (failures == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checked++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One request at a time with a fresh response credit keeps both credit pools safe
	task automatic req(input logic [5:0] t, input logic [1:0] v, input logic w,
		input logic [47:0] a, input logic [5:0] g, input logic [31:0] d);
		int n;
		sent++;
		@(posedge mclk) #1;
		reqPkt    = '{t, v, w, a, g, d};
		reqValid  = 1'b1;
		rspCredit = 1'b1;
		@(posedge mclk) #1;
		reqValid  = 1'b0;
		rspCredit = 1'b0;
		for (n = 0; n < 300 && rspValid !== 1'b1; n++)
			@(posedge mclk) #1;
		if (n == 300)
		begin
			chk(rspValid, 1'b1);
			test_done();
		end
		got = rspPkt;
		chk(got.reqTag, t);
	endtask
	task automatic acc(input logic [5:0] t, input logic [1:0] v, input logic w,
		input logic [14:0] o, input logic [31:0] d);
		req(t, v, w, BASE + {33'h0, o}, 6'h3F, d);
	endtask
	task automatic t_local();
		int n0;
		n0 = issues;
		acc(6'h02, 2'h0, 1'b1, 15'h2004, 32'hA5A5_0001);
		acc(6'h03, 2'h0, 1'b1, 15'h2004, 32'h0000_0002);
		acc(6'h02, 2'h0, 1'b0, 15'h2004, 32'h0000_0000);
		chk(got.rdata, 32'hA5A5_0001);
		acc(6'h02, 2'h1, 1'b1, 15'h2104, 32'h0000_0003);
		acc(6'h02, 2'h0, 1'b0, 15'h2104, 32'h0000_0000);
		chk(got.rdata, 32'h0000_0000);
		acc(6'h02, 2'h1, 1'b0, 15'h2104, 32'h0000_0000);
		chk(got.rdata, 32'h0000_0003);
		acc(6'h10, 2'h0, 1'b0, 15'h2004, 32'h0000_0000);
		chk(got.err, 1'b1);
		chk(issues, n0);
	endtask
	task automatic t_redirect();
		acc(6'h02, 2'h0, 1'b1, 15'h2018, 32'h0000_0003);
		acc(6'h02, 2'h0, 1'b0, 15'h4004, 32'h0000_0000);
		chk(got.rdata, 32'h0000_0002);
		acc(6'h02, 2'h0, 1'b1, 15'h4008, 32'h0000_0007);
		acc(6'h03, 2'h0, 1'b0, 15'h2008, 32'h0000_0000);
		chk(got.rdata, 32'h0000_0007);
		acc(6'h02, 2'h0, 1'b1, 15'h2018, 32'h0000_0007);
		acc(6'h02, 2'h0, 1'b0, 15'h4004, 32'h0000_0000);
		chk(got.err, 1'b1);
	endtask
	task automatic t_ring();
		logic [5:0]  tg [12] = '{6'h22, 6'h24, 6'h00, 6'h05, 6'h10, 6'h11, 6'h18, 6'h19,
			6'h1A, 6'h21, 6'h23, 6'h25};
		logic [47:0] a;
		for (int i = 0; i < 12; i++)
		begin
			a = i == 0 ? BASE + 48'h0010 : i == 1 ? BASE + 48'h6010 : 48'h0040 + 48'(i * 4);
			req(6'h01, 2'h0, 1'b0, a, tg[i], 32'h0000_0000);
			chk(lastOut.destinationTag, tg[i]);
			chk(lastOut.sourceTag, 6'h20);
			chk(got.err, tg[i] == 6'h1A || tg[i] == 6'h19);
			if (tg[i] != 6'h1A && tg[i] != 6'h19)
				chk(got.rdata, {11'h000, tg[i], a[14:0]});
		end
	endtask
	task automatic t_reserved();
		logic [5:0] bad [3] = '{6'h06, 6'h12, 6'h30};
		int         n0;
		n0 = issues;
		for (int i = 0; i < 3; i++)
		begin
			req(6'h00, 2'h0, 1'b1, 48'h0080, bad[i], 32'h0000_0001);
			chk(got.err, 1'b1);
		end
		chk(issues, n0);
	endtask
	task automatic inj(input rrr_pkt_s p);
		@(posedge mclk) #1;
		injPkt = p;
		injV   = 1'b1;
		@(posedge mclk) #1;
		injV   = 1'b0;
		injPkt = ~p;
	endtask
	task automatic t_ringio();
		rrr_pkt_s p;
		int       n;
		p = '{1'b1, 1'b0, 6'h05, 6'h23, 15'h0123, 32'h1357_9BDF};
		inj(p);
		chk(ringOutValid, 1'b1);
		chk(ringOutPkt, p);
		p.destinationTag = 6'h20;
		inj(p);
		for (n = 0; n < 8 && !(ringOutValid === 1'b1 && !ringOutPkt.isReq); n++)
			@(posedge mclk) #1;
		chk(n < 8, 1'b1);
		chk({ringOutPkt.destinationTag, ringOutPkt.sourceTag}, {6'h23, 6'h20});
	endtask
	initial
	begin
		repeat (16) @(posedge mclk);
		#1 nrst = 1'b1;
		t_local();
		t_redirect();
		t_ring();
		t_reserved();
		t_ringio();
		chk(rsps, sent);
		chk(credits, sent + 2);
		test_done();
	end
endmodule

// ===== verilog/rrr_params.svh
// Constants of the register ring router
`ifndef RRR_PARAMS_SVH
`define RRR_PARAMS_SVH
`define RRR_TAG_W          6
`define RRR_TAG_CORE_LAST  6'h05
`define RRR_TAG_IOU0       6'h10
`define RRR_TAG_IOU1       6'h11
`define RRR_TAG_IRQ        6'h18
`define RRR_TAG_USER       6'h19
`define RRR_TAG_MEM        6'h1A
`define RRR_TAG_MGR        6'h20
`define RRR_TAG_PWR        6'h21
`define RRR_TAG_CFG        6'h22
`define RRR_TAG_DBG_MST    6'h23
`define RRR_TAG_DBG_NORM   6'h24
`define RRR_TAG_DBG_SEG    6'h25
`define RRR_TAG_NODEST_ERR 6'h3E
`define RRR_TAG_NODEST_OK  6'h3F
`define RRR_WIN_LSB        15
`define RRR_SUB_GLOBAL     2'h0
`define RRR_SUB_LOCAL      2'h1
`define RRR_SUB_OTHER      2'h2
`define RRR_SUB_DEBUG      2'h3
`define RRR_NUM_CORES      6
`define RRR_NUM_PROCS      4
`define RRR_LOCAL_REGS     8
`define RRR_REDIRECT_IDX   3'h6
`define RRR_PROC_SEL_BIT   8
`define RRR_REQ_CREDITS    2'h2
`define RRR_RSP_CREDIT_MAX 2'h3
`endif

// ===== verilog/rrr_pkg.sv
// Types of the register ring router
package rrr_pkg;
	typedef struct packed
	{
		logic [5:0]  reqTag;
		logic [1:0]  virtualProcessor;
		logic        write;
		logic [47:0] addr;
		logic [5:0]  agentTag;
		logic [31:0] wdata;
	} rrr_req_s;
	typedef struct packed
	{
		logic [5:0]  reqTag;
		logic        err;
		logic [31:0] rdata;
	} rrr_rsp_s;
	typedef struct packed
	{
		logic        isReq;
		logic        write;
		logic [5:0]  destinationTag;
		logic [5:0]  sourceTag;
		logic [14:0] addr;
		logic [31:0] data;
	} rrr_pkt_s;
	typedef enum logic [1:0] {ST_IDLE, ST_RING, ST_REPLY} rrr_state_e;
endpackage

// ===== verilog/rrr_router.sv
// Coherence manager register ring router and config window decoder
// Behaviour
// - Six-bit tags, packets carry destination and source
// - Agent accepts only packets tagged with its own
// - Tags 0x00-0x05 cores, 0x10-0x11 I/O units
// - 0x18-0x1A and 0x20-0x25 name system agents
// - 0x3E/0x3F no-destination codes, rest reserved
// - Only manager and debug unit initiate; all answer
// - Manager tags request, drives it through master port
// - Matching slave returns read data to manager slave port
// - Returned data goes back on response channel
// - Three one-way channels with credit flow control; only request and response use credits here, ring ports have none
// - 32 KB window, base bits 47:15, low bits zero
// - Offsets 0x0000-0x1FFF reach global control block
// - Offsets 0x2000-0x3FFF alias requester's local block
// - Offsets 0x4000-0x5FFF reach redirected core's block
// - Offsets 0x6000-0x7FFF reach global debug block
// - Per-core and per-virtual-processor copies steered to issuer
`timescale 1ns/10ps
`include "rrr_params.svh"
module rrr_router
	import rrr_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic [47:15] configWindowBase,
	input  wire logic        reqValid,
	input  wire rrr_req_s    reqPkt,
	output logic             reqCredit,
	output logic             rspValid,
	output rrr_rsp_s         rspPkt,
	input  wire logic        rspCredit,
	input  wire logic        ringInValid,
	input  wire rrr_pkt_s    ringInPkt,
	output logic             ringOutValid,
	output rrr_pkt_s         ringOutPkt
);
	// Tag validity: only tags assigned to an agent may be driven
	function automatic logic tagAssigned(input logic [5:0] t);
		tagAssigned = (t <= `RRR_TAG_CORE_LAST)
			|| (t == `RRR_TAG_IOU0) || (t == `RRR_TAG_IOU1)
			|| ((t >= `RRR_TAG_IRQ) && (t <= `RRR_TAG_MEM))
			|| ((t >= `RRR_TAG_MGR) && (t <= `RRR_TAG_DBG_SEG));
	endfunction

	// Flat index into the per-virtual-processor copies
	function automatic logic [4:0] procSlot(input logic [2:0] c, input logic [1:0] v);
		procSlot = {c[2:0], v};
	endfunction

	rrr_req_s    reqQ [2];
	logic        wrPtr_r;
	logic        rdPtr_r;
	logic [1:0]  qCount_r;
	logic [1:0]  initLeft_r;
	logic [1:0]  rspCredits_r;
	rrr_state_e  state_r;
	rrr_state_e  state_nxt;
	rrr_rsp_s    rsp_r;
	rrr_rsp_s    rsp_nxt;
	logic        slvPend_r;
	rrr_pkt_s    slvPkt_r;
	logic        outValid_r;
	rrr_pkt_s    outPkt_r;
	logic [31:0] coreRegs [`RRR_NUM_CORES][`RRR_LOCAL_REGS];
	logic [31:0] procRegs [32][`RRR_LOCAL_REGS];

	rrr_req_s    headReq;
	logic        qNotEmpty;
	logic        popQ;
	logic        pushQ;
	logic        inWindow;
	logic [1:0]  subBlock;
	logic        localHit;
	logic        requesterIsCore;
	logic [2:0]  ownCore;
	logic [31:0] redirectVal;
	logic [2:0]  targetCore;
	logic        localErr;
	logic        procSel;
	logic [2:0]  regIdx;
	logic [31:0] localRead;
	logic        localWrite;
	logic [5:0]  ringDest;
	logic        ringGo;
	logic        forMe;
	logic        passOn;
	logic        answerIn;
	logic        unclaimedIn;
	logic        slaveHit;
	logic        rspFire;

	assign headReq   = reqQ[rdPtr_r];
	assign qNotEmpty = (qCount_r != 2'h0);
	assign pushQ     = reqValid;
	assign rspFire   = (state_r == ST_REPLY) && (rspCredits_r != 2'h0);
	assign popQ      = rspFire;
	// Initial credits are handed out one per cycle while no pop returns one
	assign reqCredit = popQ || (initLeft_r != 2'h0);
	assign rspValid  = rspFire;
	assign rspPkt    = rsp_r;

	// Window decode; base bits below 15 never take part
	assign inWindow = (headReq.addr[47:`RRR_WIN_LSB] == configWindowBase);
	assign subBlock = headReq.addr[14:13];
	assign localHit = inWindow
		&& ((subBlock == `RRR_SUB_LOCAL) || (subBlock == `RRR_SUB_OTHER));
	assign requesterIsCore = (headReq.reqTag <= `RRR_TAG_CORE_LAST);
	assign ownCore     = headReq.reqTag[2:0];
	assign redirectVal = coreRegs[requesterIsCore ? ownCore : 3'h0][`RRR_REDIRECT_IDX];
	assign targetCore  = (subBlock == `RRR_SUB_OTHER) ? redirectVal[2:0] : ownCore;
	// I/O units own no local block; redirect past the last core is refused
	assign localErr    = !requesterIsCore || (targetCore > 3'h5);
	assign procSel     = headReq.addr[`RRR_PROC_SEL_BIT];
	assign regIdx      = headReq.addr[4:2];
	assign localRead   = localErr ? 32'h0000_0000
		: procSel ? procRegs[procSlot(targetCore, headReq.virtualProcessor)][regIdx]
		: coreRegs[targetCore][regIdx];
	assign localWrite  = (state_r == ST_IDLE) && qNotEmpty && localHit
		&& !localErr && headReq.write;

	// Destination selection for requests that leave over the ring
	assign ringDest = !inWindow ? headReq.agentTag
		: (subBlock == `RRR_SUB_GLOBAL) ? `RRR_TAG_CFG
		: `RRR_TAG_DBG_NORM;

	// Ring station of the manager
	assign forMe       = ringInValid && (ringInPkt.destinationTag == `RRR_TAG_MGR);
	assign answerIn    = forMe && !ringInPkt.isReq;
	assign slaveHit    = forMe && ringInPkt.isReq
		&& (ringInPkt.sourceTag != `RRR_TAG_MGR);
	// A request of ours that comes all the way round was claimed by nobody
	assign unclaimedIn = ringInValid && ringInPkt.isReq
		&& (ringInPkt.sourceTag == `RRR_TAG_MGR)
		&& (ringInPkt.destinationTag != `RRR_TAG_MGR);
	assign passOn      = ringInValid && !forMe && !unclaimedIn;
	// Through traffic first so the ring never stalls; new issue waits
	assign ringGo      = (state_r == ST_IDLE) && qNotEmpty && !localHit
		&& tagAssigned(ringDest) && !passOn && !slvPend_r;

	always_comb
	begin
		state_nxt = state_r;
		rsp_nxt   = rsp_r;
		unique case (state_r)
			ST_IDLE:
			begin
				if (qNotEmpty && localHit)
				begin
					rsp_nxt   = '{reqTag: headReq.reqTag, err: localErr, rdata: localRead};
					state_nxt = ST_REPLY;
				end
				else if (qNotEmpty && !tagAssigned(ringDest))
				begin
					rsp_nxt   = '{reqTag: headReq.reqTag, err: 1'b1, rdata: 32'h0000_0000};
					state_nxt = ST_REPLY;
				end
				else if (ringGo)
				begin
					state_nxt = ST_RING;
				end
			end
			ST_RING:
			begin
				if (answerIn)
				begin
					rsp_nxt   = '{reqTag: headReq.reqTag,
						err: (ringInPkt.sourceTag == `RRR_TAG_NODEST_ERR),
						rdata: ringInPkt.data};
					state_nxt = ST_REPLY;
				end
				else if (unclaimedIn)
				begin
					rsp_nxt   = '{reqTag: headReq.reqTag, err: 1'b1, rdata: 32'h0000_0000};
					state_nxt = ST_REPLY;
				end
			end
			ST_REPLY:
			begin
				if (rspFire)
				begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r <= ST_IDLE;
			rsp_r   <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			rsp_r   <= rsp_nxt;
		end
	end

	// Request queue; credits guarantee a free slot on every push
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			wrPtr_r  <= 1'b0;
			rdPtr_r  <= 1'b0;
			qCount_r <= 2'h0;
			reqQ[0]  <= '0;
			reqQ[1]  <= '0;
		end
		else
		begin
			if (pushQ)
			begin
				reqQ[wrPtr_r] <= reqPkt;
				wrPtr_r       <= !wrPtr_r;
			end
			if (popQ)
			begin
				rdPtr_r <= !rdPtr_r;
			end
			qCount_r <= qCount_r + {1'b0, pushQ} - {1'b0, popQ};
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			initLeft_r   <= `RRR_REQ_CREDITS;
			rspCredits_r <= 2'h0;
		end
		else
		begin
			if (!popQ && (initLeft_r != 2'h0))
			begin
				initLeft_r <= initLeft_r - 2'h1;
			end
			if (rspCredit && !rspFire && (rspCredits_r != `RRR_RSP_CREDIT_MAX))
			begin
				rspCredits_r <= rspCredits_r + 2'h1;
			end
			else if (rspFire && !rspCredit)
			begin
				rspCredits_r <= rspCredits_r - 2'h1;
			end
		end
	end

	// Local copies; the manager answers these without using the ring
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int c = 0; c < `RRR_NUM_CORES; c++)
			begin
				for (int r = 0; r < `RRR_LOCAL_REGS; r++)
				begin
					coreRegs[c][r] <= 32'h0000_0000;
				end
			end
			for (int v = 0; v < 32; v++)
			begin
				for (int r = 0; r < `RRR_LOCAL_REGS; r++)
				begin
					procRegs[v][r] <= 32'h0000_0000;
				end
			end
		end
		else if (localWrite)
		begin
			if (procSel)
			begin
				procRegs[procSlot(targetCore, headReq.virtualProcessor)][regIdx] <= headReq.wdata;
			end
			else
			begin
				coreRegs[targetCore][regIdx] <= headReq.wdata;
			end
		end
	end

	// Manager as ring slave: answers with its queue and state
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			slvPend_r <= 1'b0;
			slvPkt_r  <= '0;
		end
		else if (slaveHit && !slvPend_r)
		begin
			slvPend_r <= 1'b1;
			slvPkt_r  <= '{isReq: 1'b0, write: ringInPkt.write,
				destinationTag: ringInPkt.sourceTag, sourceTag: `RRR_TAG_MGR,
				addr: ringInPkt.addr, data: {28'h000_0000, qCount_r, state_r}};
		end
		else if (slvPend_r && !passOn)
		begin
			slvPend_r <= 1'b0;
		end
	end

	// Ring master port
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			outValid_r <= 1'b0;
			outPkt_r   <= '0;
		end
		else
		begin
			outValid_r <= passOn || slvPend_r || ringGo;
			if (passOn)
			begin
				outPkt_r <= ringInPkt;
			end
			else if (slvPend_r)
			begin
				outPkt_r <= slvPkt_r;
			end
			else if (ringGo)
			begin
				outPkt_r <= '{isReq: 1'b1, write: headReq.write,
					destinationTag: ringDest, sourceTag: `RRR_TAG_MGR,
					addr: headReq.addr[14:0], data: headReq.wdata};
			end
		end
	end

	assign ringOutValid = outValid_r;
	assign ringOutPkt   = outPkt_r;
endmodule
